// >>> rtl/pic_consts.svh
// register offsets, field positions, reset values for the interrupt controller
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

`define ADDR_W            16
`define OFS_LEVEL_GROUP6  16'hF628
`define OFS_LEVEL_GROUP7  16'hF62C
`define OFS_MASK_LEVEL    16'hF640
`define OFS_EDGE_CLEAR    16'hF660
`define OFS_PENDING       16'hF680
`define OFS_CURRENT       16'hF6A0
`define OFS_EVENT_STATUS  16'hF6B0
`define OFS_EVENT_MASK    16'hF6B4

`define FLD_HI_LSB        24
`define FLD_MID_LSB       16
`define FLD_LO_LSB        8
`define FLD_BASE_LSB      0
`define FLD_CLEAR_GO      8
`define FLD_FLAG          16
`define FLD_REP_LEVEL_LSB 8

`define SEL_EXT_FIRST     4'h2
`define SEL_EXT_LAST      4'h9
`define EXT_SRC_BASE      2
`define NUM_EXT           8
`define NUM_SRC           31
`define PENDING_TOP       20
`define PENDING_RSVD_A    0
`define PENDING_RSVD_B    10

`define RST_LEVEL         3'h0
`define RST_MASK          3'h0
`define RST_FLAG          1'b1
`define RST_CAUSE         5'h1F

`define EVT_REQ_RAISED    0
`define EVT_EXT_EDGE      1
`define NUM_EVT           2

`endif

// >>> rtl/pic_pkg.sv
// types shared by the interrupt controller files
package pic_pkg;
   typedef logic [2:0] level_t;
   typedef logic [4:0] cause_t;
endpackage

// >>> rtl/edge_latch_bank.sv
// synchronised rising-edge latches for the external interrupt pins
`timescale 1ns/1ps
module edge_latch_bank #(
   parameter int N = 8
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [N-1:0] ext_pin,
   input  wire logic [N-1:0] clr,
   output logic      [N-1:0] latch_q,
   output logic      [N-1:0] edge_seen
);
   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic [N-1:0] prev_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= ext_pin;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         assign edge_seen[i] = sync2_q[i] & ~prev_q[i];
         // a new edge wins over a clear in the same cycle
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               latch_q[i] <= 1'b0;
            end else if (edge_seen[i]) begin
               latch_q[i] <= 1'b1;
            end else if (clr[i]) begin
               latch_q[i] <= 1'b0; // [RL5]
            end
         end
      end
   endgenerate
endmodule

// >>> rtl/priority_interrupt_controller.sv
// prioritising interrupt controller: levels, mask level, edge clear, status views
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "pic_consts.svh"
// Behaviour
// [RL1] 3-bit level per source, zero disables
// [RL2] group6: src29, src28, src13, src12 fields
// [RL3] group7: src30, src15, src14 fields, rest reserved
// [RL4] global mask suppresses levels not above it
// [RL5] clear bit clears selected external edge latch
// [RL6] clear bit self-clears, always reads zero
// [RL7] selector 2..9 maps external 0..7, others ignored
// [RL8] pending bits read-only, follow live requests
// [RL9] pending bit positions per source, 0/10 reserved
// [RL10] flag bit reads zero while requesting core
// [RL11] reported level of presented request, resets zero
// [RL12] reported cause number, resets to 0x1F
// [RL13] cause code equals source index
// [RL14] highest level wins, ties to lower number
module priority_interrupt_controller
   import pic_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output logic      [31:0]          rdata,
   input  wire logic [`NUM_SRC-1:0]  int_src_req,
   input  wire logic [`NUM_EXT-1:0]  ext_int_pin,
   output logic                      core_req,
   output level_t                    core_level,
   output cause_t                    core_cause,
   output logic                      irq
);
   level_t lvl12_q, lvl13_q, lvl14_q, lvl15_q;
   level_t lvl28_q, lvl29_q, lvl30_q;
   level_t mask_q;
   logic [3:0] sel_q;
   logic       flag_q;
   level_t     rep_lvl_q;
   cause_t     rep_cause_q;
   logic [`NUM_EVT-1:0] evt_stat_q;
   logic [`NUM_EVT-1:0] evt_mask_q;
   logic [31:0] rdata_q;

   logic [`NUM_EXT-1:0] ext_latch;
   logic [`NUM_EXT-1:0] ext_edge;
   logic [`NUM_EXT-1:0] ext_clr;
   logic [`NUM_SRC-1:0] req_vec;
   level_t              src_lvl [`NUM_SRC];
   logic                win_found;
   level_t              win_lvl;
   cause_t              win_cause;
   logic [`NUM_EVT-1:0] evt_set;
   logic                wr_clear;

   edge_latch_bank #(.N(`NUM_EXT)) u_edges (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .ext_pin   (ext_int_pin),
      .clr       (ext_clr),
      .latch_q   (ext_latch),
      .edge_seen (ext_edge)
   );

   // level registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lvl12_q <= `RST_LEVEL; // [RL1]
         lvl13_q <= `RST_LEVEL;
         lvl14_q <= `RST_LEVEL;
         lvl15_q <= `RST_LEVEL;
         lvl28_q <= `RST_LEVEL;
         lvl29_q <= `RST_LEVEL;
         lvl30_q <= `RST_LEVEL;
      end else if (wr_stb && addr == `OFS_LEVEL_GROUP6) begin
         lvl29_q <= wdata[`FLD_HI_LSB +: 3];   // [RL2]
         lvl28_q <= wdata[`FLD_MID_LSB +: 3];
         lvl13_q <= wdata[`FLD_LO_LSB +: 3];
         lvl12_q <= wdata[`FLD_BASE_LSB +: 3];
      end else if (wr_stb && addr == `OFS_LEVEL_GROUP7) begin
         lvl30_q <= wdata[`FLD_MID_LSB +: 3];  // [RL3]
         lvl15_q <= wdata[`FLD_LO_LSB +: 3];
         lvl14_q <= wdata[`FLD_BASE_LSB +: 3];
      end
   end

   // global mask level
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= `RST_MASK;
      end else if (wr_stb && addr == `OFS_MASK_LEVEL) begin
         mask_q <= wdata[2:0]; // [RL4]
      end
   end

   // edge clear command: selector kept, go bit never stored
   assign wr_clear = wr_stb && addr == `OFS_EDGE_CLEAR;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sel_q <= 4'h0;
      end else if (wr_clear) begin
         sel_q <= wdata[3:0];
      end
   end

   genvar e;
   generate
      for (e = 0; e < `NUM_EXT; e++) begin : g_clr
         assign ext_clr[e] = wr_clear && wdata[`FLD_CLEAR_GO] // [RL5]
                             && wdata[3:0] == 4'(e + `EXT_SRC_BASE); // [RL7]
      end
   endgenerate

   // request vector and per-source levels
   genvar s;
   generate
      for (s = 0; s < `NUM_SRC; s++) begin : g_src
         if (s >= `EXT_SRC_BASE && s < `EXT_SRC_BASE + `NUM_EXT) begin : g_ext
            assign req_vec[s] = ext_latch[s - `EXT_SRC_BASE];
         end else if (s == `PENDING_RSVD_A || s == `PENDING_RSVD_B) begin : g_rsv
            assign req_vec[s] = 1'b0; // [RL9]
         end else begin : g_int
            assign req_vec[s] = int_src_req[s];
         end
      end
   endgenerate

   always_comb begin
      for (int k = 0; k < `NUM_SRC; k++) begin
         src_lvl[k] = 3'h0;
      end
      src_lvl[12] = lvl12_q;
      src_lvl[13] = lvl13_q;
      src_lvl[14] = lvl14_q;
      src_lvl[15] = lvl15_q;
      src_lvl[28] = lvl28_q;
      src_lvl[29] = lvl29_q;
      src_lvl[30] = lvl30_q;
   end

   // arbitration: ascending scan, strictly higher level replaces
   always_comb begin
      win_found = 1'b0;
      win_lvl   = 3'h0;
      win_cause = `RST_CAUSE;
      for (int k = 1; k < `NUM_SRC; k++) begin
         if (req_vec[k] && src_lvl[k] != 3'h0 && src_lvl[k] > mask_q) begin // [RL1] [RL4]
            if (!win_found || src_lvl[k] > win_lvl) begin // [RL14]
               win_found = 1'b1;
               win_lvl   = src_lvl[k];
               win_cause = 5'(k); // [RL13]
            end
         end
      end
   end

   // current request presented to the core
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q      <= `RST_FLAG;  // [RL10]
         rep_lvl_q   <= `RST_LEVEL; // [RL11]
         rep_cause_q <= `RST_CAUSE; // [RL12]
      end else begin
         flag_q <= ~win_found; // [RL10]
         if (win_found) begin
            rep_lvl_q   <= win_lvl;   // [RL11]
            rep_cause_q <= win_cause; // [RL12]
         end
      end
   end

   assign core_req   = ~flag_q;
   assign core_level = rep_lvl_q;
   assign core_cause = rep_cause_q;

   // block events: request raised, external edge captured
   always_comb begin
      evt_set = '0;
      evt_set[`EVT_REQ_RAISED] = win_found & flag_q;
      evt_set[`EVT_EXT_EDGE]   = |ext_edge;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         evt_stat_q <= '0;
      end else if (rd_stb && addr == `OFS_EVENT_STATUS) begin
         evt_stat_q <= evt_set; // set wins over read clear
      end else begin
         evt_stat_q <= evt_stat_q | evt_set;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         evt_mask_q <= '0;
      end else if (wr_stb && addr == `OFS_EVENT_MASK) begin
         evt_mask_q <= wdata[`NUM_EVT-1:0];
      end
   end

   assign irq = |(evt_stat_q & evt_mask_q);

   // register read, data valid only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (rd_stb) begin
            unique case (addr)
               `OFS_LEVEL_GROUP6: begin
                  rdata_q[`FLD_HI_LSB +: 3]   <= lvl29_q; // [RL2]
                  rdata_q[`FLD_MID_LSB +: 3]  <= lvl28_q;
                  rdata_q[`FLD_LO_LSB +: 3]   <= lvl13_q;
                  rdata_q[`FLD_BASE_LSB +: 3] <= lvl12_q;
               end
               `OFS_LEVEL_GROUP7: begin
                  rdata_q[`FLD_MID_LSB +: 3]  <= lvl30_q; // [RL3]
                  rdata_q[`FLD_LO_LSB +: 3]   <= lvl15_q;
                  rdata_q[`FLD_BASE_LSB +: 3] <= lvl14_q;
               end
               `OFS_MASK_LEVEL: begin
                  rdata_q[2:0] <= mask_q;
               end
               `OFS_EDGE_CLEAR: begin
                  rdata_q[3:0] <= sel_q; // [RL6]
               end
               `OFS_PENDING: begin
                  rdata_q[`PENDING_TOP:0] <= req_vec[`PENDING_TOP:0]; // [RL8] [RL9]
               end
               `OFS_CURRENT: begin
                  rdata_q[`FLD_FLAG]                <= flag_q;      // [RL10]
                  rdata_q[`FLD_REP_LEVEL_LSB +: 3]  <= rep_lvl_q;   // [RL11]
                  rdata_q[4:0]                      <= rep_cause_q; // [RL12]
               end
               `OFS_EVENT_STATUS: begin
                  rdata_q[`NUM_EVT-1:0] <= evt_stat_q;
               end
               `OFS_EVENT_MASK: begin
                  rdata_q[`NUM_EVT-1:0] <= evt_mask_q;
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign rdata = rdata_q;
endmodule

// >>> verification/pic_monitor.sv
// port checker for the interrupt controller, bound into the top module
`timescale 1ns/1ps
`include "pic_consts.svh"
module pic_monitor
   import pic_pkg::*;
(
   input wire logic                mclk,
   input wire logic                rst_b,
   input wire logic [`ADDR_W-1:0]  addr,
   input wire logic                rd_stb,
   input wire logic [31:0]         rdata,
   input wire logic [`NUM_SRC-1:0] int_src_req,
   input wire logic                core_req,
   input wire level_t              core_level,
   input wire cause_t              core_cause
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic                rd_cur;
   logic                rd_clr;
   logic                rd_pnd;
   logic [`NUM_SRC-1:0] req_q;
   assign rd_cur = rd_stb && addr == `OFS_CURRENT;
   assign rd_clr = rd_stb && addr == `OFS_EDGE_CLEAR;
   assign rd_pnd = rd_stb && addr == `OFS_PENDING;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= '0;
      end else begin
         req_q <= int_src_req;
      end
   end
   AST_RESET: assert property ($rose(rst_b) |-> !core_req && core_cause == 5'h1F)
      else $error("reset values wrong");
   AST_IDLE: assert property (!$past(rd_stb) |-> rdata == 32'h0)
      else $error("read data outside read cycle");
   AST_FLAG: assert property ($past(rd_cur) |-> rdata[16] == !$past(core_req))
      else $error("flag bit wrong");
   AST_LEVEL: assert property ($past(rd_cur) && $past(core_req)
      |-> rdata[10:8] == $past(core_level))
      else $error("reported level wrong");
   AST_CAUSE: assert property ($past(rd_cur) && $past(core_req)
      |-> rdata[4:0] == $past(core_cause))
      else $error("reported cause wrong");
   AST_LVL_NZ: assert property (core_req |-> core_level != 3'h0)
      else $error("request with level zero");
   AST_SRC: assert property (core_req
      |-> core_cause inside {5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h1C, 5'h1D, 5'h1E})
      else $error("cause outside level sources");
   AST_WIN: assert property (core_req |-> req_q[core_cause])
      else $error("winner not requesting");
   AST_CLR_RD: assert property ($past(rd_clr) |-> !rdata[8])
      else $error("clear enable reads one");
   AST_PEND: assert property ($past(rd_pnd)
      |-> rdata[31:11] == {11'h0, req_q[20:11]}
      && rdata[1:0] == {req_q[1], 1'b0} && !rdata[10])
      else $error("pending bits wrong");
endmodule
bind priority_interrupt_controller pic_monitor mon (.mclk(mclk), .rst_b(rst_b), .addr(addr),
   .rd_stb(rd_stb), .rdata(rdata), .int_src_req(int_src_req), .core_req(core_req),
   .core_level(core_level), .core_cause(core_cause));

// >>> verification/core_model.sv
// behavioural core that takes the presented cause after a chosen lag
`timescale 1ns/1ps
module core_model
   import pic_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       core_req,
   input  wire cause_t     core_cause,
   input  wire logic [1:0] lag,
   output cause_t          taken_q
);
   logic [1:0] wait_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 2'h0;
         taken_q <= 5'h1F;
      end else if (!core_req) begin
         wait_q <= 2'h0;
      end else if (wait_q == lag) begin
         taken_q <= core_cause;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// >>> verification/tb_priority_interrupt_controller.sv
// self-checking bench for the prioritising interrupt controller
`timescale 1ns/1ps
`include "pic_consts.svh"
module tb_priority_interrupt_controller
   import pic_pkg::*;
;
   logic        mclk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, core_req, irq;
   logic [15:0] addr = 16'h0;
   logic [31:0] wdata = 32'h0, rdata, r, r2, r3, e;
   logic [30:0] int_src_req = 31'h0, rq;
   logic [7:0]  ext_int_pin = 8'h0;
   logic [1:0]  lag = 2'h0;
   level_t      core_level, lv [31];
   cause_t      core_cause, taken_q;
   int          mismatches = 0, checks = 0, seed = 32'hd84101a6;
   int          srcs [7] = '{12, 13, 14, 15, 28, 29, 30};
   logic [15:0] rst_addr [7] = '{16'hF628, 16'hF62C, 16'hF640, 16'hF660,
                                 16'hF680, 16'hF6A0, 16'hF700};
   logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0001001F, 32'h0};
   always #5 mclk = ~mclk;
   priority_interrupt_controller dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .int_src_req(int_src_req),
      .ext_int_pin(ext_int_pin), .core_req(core_req), .core_level(core_level),
      .core_cause(core_cause), .irq(irq));
   core_model far (.mclk(mclk), .rst_b(rst_b), .core_req(core_req), .core_cause(core_cause),
      .lag(lag), .taken_q(taken_q));
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m, string s);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk((rdata & m) === (x & m), s);
   endtask
   function automatic logic [31:0] expect_cur(input logic [30:0] q, input level_t mk);
      level_t bl;
      cause_t bc;
      bl = 3'h0;
      bc = 5'h1F;
      foreach (srcs[k]) begin
         if (q[srcs[k]] && lv[srcs[k]] > mk && lv[srcs[k]] > bl) begin
            bl = lv[srcs[k]];
            bc = 5'(srcs[k]);
         end
      end
      return {15'h0, bl == 3'h0, 5'h0, bl, 3'h0, bc};
   endfunction
   task automatic reset_and_check;
      @(posedge mclk);
      rst_b <= 1'b0;
      int_src_req <= 31'h0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (rst_addr[k]) rd(rst_addr[k], rst_val[k], '1, "reset value");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      reset_and_check();
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         r3 = $random(seed);
         rq = 31'($random(seed));
         if (i < 2) begin
            r = 32'h03030303;
            r2 = 32'h00030303;
            r3 = i ? 32'h2 : 32'h3;
            rq = '1;
         end
         {lv[29], lv[28], lv[13], lv[12]} = {r[26:24], r[18:16], r[10:8], r[2:0]};
         {lv[30], lv[15], lv[14]} = {r2[18:16], r2[10:8], r2[2:0]};
         wr(`OFS_LEVEL_GROUP6, r);
         rd(`OFS_LEVEL_GROUP6, r & 32'h07070707, '1, "group6 readback");
         wr(`OFS_LEVEL_GROUP7, r2);
         rd(`OFS_LEVEL_GROUP7, r2 & 32'h00070707, '1, "group7 readback");
         wr(`OFS_MASK_LEVEL, r3);
         rd(`OFS_MASK_LEVEL, r3 & 32'h7, '1, "mask readback");
         @(posedge mclk);
         int_src_req <= rq;
         lag <= r3[5:4];
         repeat (6) @(posedge mclk);
         e = expect_cur(rq, r3[2:0]);
         rd(`OFS_CURRENT, e, e[16] ? 32'h00010000 : 32'h0001071F, "current status");
         rd(`OFS_PENDING, {11'h0, rq[20:11], 9'h0, rq[1], 1'b0}, 32'hFFFFFC03, "pending");
         chk(core_req === !e[16], "core request line");
         if (!e[16]) chk(core_level === e[10:8], "core level line");
         if (!e[16]) chk(taken_q === e[4:0], "core took cause");
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         ext_int_pin[i] <= 1'b1;
         repeat (5) @(posedge mclk);
         ext_int_pin[i] <= 1'b0;
         rd(`OFS_PENDING, 32'h1 << (i + 2), 32'h3FC, "edge latched");
         wr(`OFS_EDGE_CLEAR, 32'(i + 2));
         rd(`OFS_PENDING, 32'h1 << (i + 2), 32'h3FC, "clear without enable");
         wr(`OFS_EDGE_CLEAR, 32'h100 | 32'(i < 2 ? i : i + 8));
         rd(`OFS_PENDING, 32'h1 << (i + 2), 32'h3FC, "reserved selector");
         wr(`OFS_EDGE_CLEAR, 32'h100 | 32'(i + 2));
         rd(`OFS_EDGE_CLEAR, 32'(i + 2), 32'h10F, "clear register readback");
         rd(`OFS_PENDING, 32'h0, 32'h3FC, "edge cleared");
      end
      @(posedge mclk);
      int_src_req <= 31'h0;
      wr(`OFS_LEVEL_GROUP6, 32'h5);
      wr(`OFS_MASK_LEVEL, 32'h0);
      wr(`OFS_EVENT_MASK, 32'h0);
      rd(`OFS_EVENT_STATUS, 32'h2, 32'h2, "edge event held in status");
      @(posedge mclk);
      int_src_req <= 31'h1000;
      repeat (3) @(posedge mclk);
      #1 chk(irq === 1'b0, "masked event");
      wr(`OFS_EVENT_MASK, 32'h1);
      #1 chk(irq === 1'b1, "unmasked event");
      rd(`OFS_EVENT_STATUS, 32'h1, 32'h3, "event status");
      chk(irq === 1'b0, "status cleared by read");
      reset_and_check();
      tally_and_finish();
   end
endmodule
